// ---- rtl/ggw_pkg.sv ----
// Constants, types and decode helpers for the gesture gain, drive, wait
// and crosstalk offset register bank.
// Assumes a single 100 MHz clock and an 8-bit internal register port.
`default_nettype none
package ggw_pkg;

  // ----------------------------------------------------------------------
  // Register map and reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_CFG = 8'ha3;
  localparam logic [7:0] ADDR_OFS_UP = 8'ha4;
  localparam logic [7:0] ADDR_OFS_DOWN = 8'ha5;
  localparam logic [7:0] ADDR_OFS_LEFT = 8'ha7;
  localparam logic [7:0] ADDR_OFS_RIGHT = 8'ha9;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [7:0] OFS_RESET = 8'h00;
  localparam logic [7:0] RDATA_UNMAPPED = 8'h00;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int RSVD_BIT = 7;
  localparam int GAIN_LSB = 5;
  localparam int DRIVE_LSB = 3;
  localparam int WAIT_LSB = 0;
  localparam int SIGN_BIT = 7;
  localparam logic [7:0] CFG_WR_MASK = 8'h7f;

  // ----------------------------------------------------------------------
  // Channels
  // ----------------------------------------------------------------------
  localparam int NUM_CHAN = 4;
  localparam int CH_UP = 0;
  localparam int CH_DOWN = 1;
  localparam int CH_LEFT = 2;
  localparam int CH_RIGHT = 3;
  localparam logic [NUM_CHAN-1:0][7:0] ADDR_OFS =
    {ADDR_OFS_RIGHT, ADDR_OFS_LEFT, ADDR_OFS_DOWN, ADDR_OFS_UP};

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_MHZ = 100;
  localparam int CLK_PERIOD_NS = 10;
  localparam int WAIT_STEP_US = 2800;
  localparam int WAIT_STEP_CYCLES = WAIT_STEP_US * CLK_MHZ;
  localparam int EMIT_EXT_NS = 1330;
  localparam int EMIT_EXT_CYCLES =
    (EMIT_EXT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] DRIVE_MAX_HALF_MA = 8'hc8;
  localparam logic [3:0] GAIN_UNITY = 4'h1;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {S_OFF, S_WAIT, S_INTEG, S_EXTEND} ggw_state_t;

  typedef struct packed {
    logic [3:0] gain_factor;
    logic [7:0] drive_half_ma;
    logic [2:0] wait_code;
    logic [NUM_CHAN-1:0][7:0] offset;
  } ggw_applied_t;

  // Wait interval in 2.8 ms steps: 0,2.8,5.6,8.4,14.0,22.4,30.8,39.2 ms
  function automatic logic [3:0] wait_steps(input logic [2:0] code);
    case (code)
      3'h0: wait_steps = 4'h0;
      3'h1: wait_steps = 4'h1;
      3'h2: wait_steps = 4'h2;
      3'h3: wait_steps = 4'h3;
      3'h4: wait_steps = 4'h5;
      3'h5: wait_steps = 4'h8;
      3'h6: wait_steps = 4'hb;
      default: wait_steps = 4'he;
    endcase
  endfunction

  // Sign/magnitude to two's complement; minus zero folds to zero
  function automatic logic [7:0] sm_to_twos(input logic [7:0] sm);
    logic [7:0] mag;
    mag = {1'b0, sm[6:0]};
    sm_to_twos = sm[SIGN_BIT] ? 8'(8'h00 - mag) : mag;
  endfunction

endpackage
`default_nettype wire

// ---- rtl/ggw_wait_timer.sv ----
// Low-power wait timer counting whole 2.8 ms steps.
// Assumes start is a one-cycle pulse; a new start restarts the count.
`timescale 1ns/1ps
`default_nettype none
module ggw_wait_timer #(
  parameter int unsigned STEP_CYCLES = ggw_pkg::WAIT_STEP_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic [3:0] steps,
  output logic done
);
  import ggw_pkg::*;

  logic [31:0] div;
  logic [31:0] next_div;
  logic [3:0] left;
  logic [3:0] next_left;
  logic run;
  logic next_run;
  logic next_done;
  logic tick;

  // Step divider and step counter; done lands steps*STEP_CYCLES after start
  always_comb begin
    tick = run && (div == 32'(STEP_CYCLES - 1));
    next_div = div;
    next_left = left;
    next_run = run;
    next_done = 1'b0;
    if (start) begin
      next_div = 32'h0000_0000;
      next_left = steps;
      next_run = (steps != 4'h0);
      next_done = (steps == 4'h0);
    end else if (tick) begin
      next_div = 32'h0000_0000;
      next_left = 4'(left - 4'h1);
      if (left == 4'h1) begin
        next_run = 1'b0;
        next_done = 1'b1;
      end
    end else if (run) begin
      next_div = 32'(div + 32'h0000_0001);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      div <= 32'h0000_0000;
      left <= 4'h0;
      run <= 1'b0;
      done <= 1'b0;
    end else begin
      div <= next_div;
      left <= next_left;
      run <= next_run;
      done <= next_done;
    end
  end
endmodule // ggw_wait_timer
`default_nettype wire

// ---- rtl/ggw_regs.sv ----
// Gesture gain, drive, wait and crosstalk offset register bank with the
// detection cycle pacing that consumes it.
// Assumes the host bus front end gives one-cycle read/write strobes.
//
// Notes on behaviour
// - Gain field 6:5 selects 1x to 8x
// - Drive field 4:3 selects 100 to 12.5 mA
// - Wait field 2:0 sets idle between cycles
// - Emitter stays on 1.33 us past integration
// - Offsets are sign/magnitude, +127 to -127
// - Four separate 8-bit per-direction offset registers
`timescale 1ns/1ps
`default_nettype none
module ggw_regs #(
  parameter int unsigned WAIT_STEP = ggw_pkg::WAIT_STEP_CYCLES,
  parameter int INTEG_W = 16
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic gesture_engine_enable,
  input wire logic [INTEG_W-1:0] integration_period,
  output ggw_pkg::ggw_applied_t applied,
  output logic integrating,
  output logic emitter_drive_pin,
  output logic cycle_done
);
  import ggw_pkg::*;

  // ----------------------------------------------------------------------
  // Software-visible registers
  // ----------------------------------------------------------------------
  logic [7:0] cfg;
  logic [7:0] next_cfg;
  logic [NUM_CHAN-1:0][7:0] ofs;
  logic [NUM_CHAN-1:0][7:0] next_ofs;
  logic [7:0] next_rdata;

  // Write decode; reserved bit 7 is dropped so it always reads zero
  always_comb begin
    next_cfg = cfg;
    next_ofs = ofs;
    next_rdata = reg_rdata;
    if (reg_wr && reg_addr == ADDR_CFG) begin
      next_cfg = reg_wdata & CFG_WR_MASK;
    end
    for (int i = 0; i < NUM_CHAN; i++) begin
      if (reg_wr && reg_addr == ADDR_OFS[i]) begin
        next_ofs[i] = reg_wdata;
      end
    end
    if (reg_rd) begin
      next_rdata = RDATA_UNMAPPED;
      if (reg_addr == ADDR_CFG) begin
        next_rdata = cfg;
      end
      for (int i = 0; i < NUM_CHAN; i++) begin
        if (reg_addr == ADDR_OFS[i]) begin
          next_rdata = ofs[i];
        end
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cfg <= CFG_RESET;
      ofs <= {NUM_CHAN{OFS_RESET}};
      reg_rdata <= RDATA_UNMAPPED;
    end else begin
      cfg <= next_cfg;
      ofs <= next_ofs;
      reg_rdata <= next_rdata;
    end
  end

  // ----------------------------------------------------------------------
  // Detection cycle sequencer
  // ----------------------------------------------------------------------
  ggw_state_t state;
  ggw_state_t next_state;
  logic [INTEG_W-1:0] integ_cnt;
  logic [INTEG_W-1:0] next_integ_cnt;
  logic [INTEG_W-1:0] integ_last;
  logic [7:0] ext_cnt;
  logic [7:0] next_ext_cnt;
  logic latch;
  logic wait_start;
  logic wait_done;
  logic next_cycle_done;
  ggw_applied_t next_applied;

  // A zero integration length still integrates for one cycle
  assign integ_last = (integration_period == '0) ? '0 :
                      INTEG_W'(integration_period - 1'b1);

  // Settings are only sampled as a cycle starts, never mid-cycle
  always_comb begin
    next_state = state;
    next_integ_cnt = integ_cnt;
    next_ext_cnt = ext_cnt;
    next_cycle_done = 1'b0;
    latch = 1'b0;
    case (state)
      S_OFF: begin
        if (gesture_engine_enable) begin
          latch = 1'b1;
          next_state = S_WAIT;
        end
      end
      S_WAIT: begin
        if (!gesture_engine_enable) begin
          next_state = S_OFF;
        end else if (wait_done) begin
          next_integ_cnt = '0;
          next_state = S_INTEG;
        end
      end
      S_INTEG: begin
        next_integ_cnt = INTEG_W'(integ_cnt + 1'b1);
        if (integ_cnt == integ_last) begin
          next_ext_cnt = 8'h00;
          next_state = S_EXTEND;
        end
      end
      S_EXTEND: begin
        next_ext_cnt = 8'(ext_cnt + 8'h01);
        if (ext_cnt == 8'(EMIT_EXT_CYCLES - 1)) begin
          next_cycle_done = 1'b1;
          if (gesture_engine_enable) begin
            latch = 1'b1;
            next_state = S_WAIT;
          end else begin
            next_state = S_OFF;
          end
        end
      end
      default: next_state = S_OFF;
    endcase
    wait_start = latch;
  end

  // Decoded settings for the analog path, loaded only on latch
  always_comb begin
    next_applied = applied;
    if (latch) begin
      next_applied.gain_factor = GAIN_UNITY << cfg[GAIN_LSB +: 2];
      next_applied.drive_half_ma =
        DRIVE_MAX_HALF_MA >> cfg[DRIVE_LSB +: 2];
      next_applied.wait_code = cfg[WAIT_LSB +: 3];
      for (int i = 0; i < NUM_CHAN; i++) begin
        next_applied.offset[i] = sm_to_twos(ofs[i]);
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state <= S_OFF;
      integ_cnt <= '0;
      ext_cnt <= 8'h00;
      cycle_done <= 1'b0;
      integrating <= 1'b0;
      emitter_drive_pin <= 1'b0;
      applied <= '0;
    end else begin
      state <= next_state;
      integ_cnt <= next_integ_cnt;
      ext_cnt <= next_ext_cnt;
      cycle_done <= next_cycle_done;
      integrating <= (next_state == S_INTEG);
      emitter_drive_pin <= (next_state == S_INTEG) ||
                           (next_state == S_EXTEND);
      applied <= next_applied;
    end
  end

  // Wait timer takes the value being latched in the same edge
  ggw_wait_timer #(
    .STEP_CYCLES(WAIT_STEP)
  ) u_wait (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .start(wait_start),
    .steps(wait_steps(cfg[WAIT_LSB +: 3])),
    .done(wait_done)
  );

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  // Helper: cycles spent waiting since the timer started
  logic [31:0] wait_cnt;
  always_ff @(posedge sys_clk) begin
    if (!rst_n || wait_start) begin
      wait_cnt <= 32'h0000_0000;
    end else if (state == S_WAIT) begin
      wait_cnt <= 32'(wait_cnt + 32'h0000_0001);
    end
  end

  gain_decode_a: assert property ($past(latch) |->
    applied.gain_factor == (GAIN_UNITY << $past(cfg[6:5])))
    else $error("gain factor does not match gain field");
  drive_decode_a: assert property ($past(latch) |->
    (10'(applied.drive_half_ma) << $past(cfg[4:3])) == 10'h0c8)
    else $error("drive current does not match drive field");
  wait_len_a: assert property ((state == S_WAIT && wait_done) |->
    wait_cnt == 32'(wait_steps(applied.wait_code)) * 32'(WAIT_STEP))
    else $error("wait interval length wrong");
  emit_hold_a: assert property ($fell(integrating) |->
    emitter_drive_pin [*8])
    else $error("emitter dropped with integration");
  emit_end_a: assert property ($fell(emitter_drive_pin) |->
    $past(ext_cnt) == 8'(EMIT_EXT_CYCLES - 1))
    else $error("emitter extension not 1.33 us");
  ofs_pos_a: assert property (($past(latch) && !$past(ofs[1][7])) |->
    applied.offset[1] == {1'b0, $past(ofs[1][6:0])})
    else $error("positive offset decoded wrong");
  ofs_neg_a: assert property (($past(latch) && $past(ofs[3][7])) |->
    applied.offset[3] == 8'(8'h00 - {1'b0, $past(ofs[3][6:0])}))
    else $error("negative offset decoded wrong");
  ofs_write_a: assert property ((reg_wr && reg_addr == ADDR_OFS_LEFT) |=>
    ofs[CH_LEFT] == $past(reg_wdata))
    else $error("left offset write lost");
  apply_hold_a: assert property (!$past(latch) |-> $stable(applied))
    else $error("settings changed mid-cycle");

  full_cycle_c: cover property (cycle_done && gesture_engine_enable);
  neg_offset_c: cover property (latch && ofs[CH_UP][7]);
  abort_wait_c: cover property (state == S_WAIT && !gesture_engine_enable);
endmodule // ggw_regs
`default_nettype wire

// ---- bench/ggw_regs_tb.sv ----
// Self-checking bench for the gesture gain, drive, wait and offset bank.
// Assumes ggw_pkg is compiled first; the bench drives every port itself.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin errors++; \
  $display("unexpected %s exp %0h got %0h", nm, e, g); end end
module ggw_regs_tb;
  import ggw_pkg::*;
  // ----------------------------------------------------------------------
  // Settings and signals
  // ----------------------------------------------------------------------
  localparam int STEP = 20; // Short wait step keeps the run brief
  localparam int PER = 3;
  localparam int EXT = 133;
  localparam int LIMIT = 10000;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic gesture_engine_enable = 1'b0;
  logic [15:0] integration_period = 16'h0003;
  logic [7:0] reg_rdata;
  ggw_applied_t applied;
  logic integrating;
  logic emitter_drive_pin;
  logic cycle_done;
  int errors = 0;
  int n_checks = 0;
  int cycles = 0;
  int steps_tab [8] = '{0, 1, 2, 3, 5, 8, 11, 14};
  logic [7:0] tab [8] = '{8'h7f, 8'h81, 8'hff, 8'h80, 8'h01, 8'h00, 8'hc0,
    8'h40};
  logic [7:0] sm [4];
  logic [7:0] cfg;
  logic [1:0] g;
  logic [1:0] d;
  logic [2:0] w;
  int i;
  int c;
  int n;
  int e;
  int ni;

  ggw_regs #(.WAIT_STEP(STEP), .INTEG_W(16)) i_ggw_regs (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .gesture_engine_enable(gesture_engine_enable),
    .integration_period(integration_period),
    .applied(applied),
    .integrating(integrating),
    .emitter_drive_pin(emitter_drive_pin),
    .cycle_done(cycle_done)
  );

  // ----------------------------------------------------------------------
  // Clock, hang guard and helpers
  // ----------------------------------------------------------------------
  // Free-running 100 MHz clock
  always #5 sys_clk = ~sys_clk;

  // A hang counts as a mismatch and still ends in the one verdict
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      errors++;
      close_out();
    end
  end

  // Independent sign/magnitude decode; minus zero reads as zero
  function automatic logic [7:0] exp_ofs(input logic [7:0] s);
    return s[7] ? 8'(8'h00 - {1'b0, s[6:0]}) : s;
  endfunction

  // One-cycle write strobe; the bus idles a cycle between transfers
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  // Read data lands on the same edge that takes the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] x,
    input string nm);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    `CHK(nm, x, reg_rdata)
  endtask

  task automatic close_out;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  // Reset values, unmapped place, then one detection cycle per wait code
  initial begin
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    #1;
    `CHK("applied", ggw_applied_t'(0), applied)
    // Unmapped write first, so the reset reads also prove it hit nothing
    wr(8'ha6, 8'h5a);
    rd(ADDR_CFG, CFG_RESET, "cfg reset");
    for (c = 0; c < 4; c++) begin
      rd(ADDR_OFS[c], OFS_RESET, "ofs reset");
    end
    rd(8'ha6, RDATA_UNMAPPED, "unmapped");
    for (i = 0; i < 8; i++) begin
      g = 2'(i % 4);
      d = 2'((i + 1) % 4);
      w = 3'(i);
      cfg = {1'b1, g, d, w};
      wr(ADDR_CFG, cfg);
      rd(ADDR_CFG, {1'b0, cfg[6:0]}, "cfg");
      for (c = 0; c < 4; c++) begin
        sm[c] = tab[(i + c) % 8];
        wr(ADDR_OFS[c], sm[c]);
        rd(ADDR_OFS[c], sm[c], "ofs");
      end
      @(posedge sys_clk);
      gesture_engine_enable <= 1'b1;
      // Mid-cycle write must wait for the next cycle start
      wr(ADDR_OFS_UP, 8'h33);
      n = 2;
      #1;
      while (integrating !== 1'b1 && n < 1000) begin
        @(posedge sys_clk);
        #1;
        n++;
      end
      `CHK("wait", steps_tab[i] * STEP + 2, n)
      `CHK("gain", 4'(1 << g), applied.gain_factor)
      `CHK("drive", 8'(200 >> d), applied.drive_half_ma)
      `CHK("wait code", w, applied.wait_code)
      for (c = 0; c < 4; c++) begin
        `CHK("offset", exp_ofs(sm[c]), applied.offset[c])
      end
      // Enable drops mid-cycle; the cycle still runs to its end
      e = 0;
      ni = 0;
      while (emitter_drive_pin === 1'b1 && e < 1000) begin
        e++;
        ni += int'(integrating === 1'b1);
        @(posedge sys_clk);
        gesture_engine_enable <= 1'b0;
        #1;
      end
      `CHK("integ", PER, ni)
      `CHK("emit", PER + EXT, e)
      `CHK("done", 1'b1, cycle_done)
    end
    // Enable dropped inside a long wait ends the cycle with no integration
    wr(ADDR_CFG, 8'h07);
    @(posedge sys_clk);
    gesture_engine_enable <= 1'b1;
    repeat (10) @(posedge sys_clk);
    gesture_engine_enable <= 1'b0;
    ni = 0;
    repeat (300) begin
      @(posedge sys_clk);
      #1;
      ni += int'(integrating === 1'b1);
    end
    `CHK("abort", 0, ni)
    close_out();
  end
endmodule // ggw_regs_tb
`default_nettype wire
